// >>> hdl/clk_mode_pkg.sv
// constants and types for the system clock mode control block
package clk_mode_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_IDLE_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_MODE_STATUS = 8'h08;
    localparam int         ADDR_W           = 8;
    localparam int         DATA_W           = 32;

    // ------------------------------------------------------------------
    // mode control and idle control field layout
    // ------------------------------------------------------------------
    localparam int DIV_SEL_LSB    = 5;
    localparam int DIV_SEL_MSB    = 7;
    localparam int LOW_RDY_BIT    = 3;
    localparam int HIGH_RDY_BIT   = 2;
    localparam int IDLE_SEL_BIT   = 1;
    localparam int FAST_SEL_BIT   = 0;
    localparam int KEEP_BIT       = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] RST_DIV_SEL  = 3'h0;
    localparam logic       RST_IDLE_SEL = 1'b0;
    localparam logic       RST_FAST_SEL = 1'b1;
    localparam logic       RST_KEEP     = 1'b0;

    // divider codes that pick the low speed oscillator
    localparam logic [2:0] DIV_LOW_A = 3'h0;
    localparam logic [2:0] DIV_LOW_B = 3'h1;

    // ------------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------------
    localparam int CNT_W           = 5;
    localparam int HIGH_RDY_CYCLES = 15;
    localparam int LOW_RDY_CYCLES  = 1;

    // ------------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL    = 3'b000,
        MODE_SLOW      = 3'b001,
        MODE_SLEEP     = 3'b010,
        MODE_IDLE_STOP = 3'b011,
        MODE_IDLE_KEEP = 3'b100
    } op_mode_t;

endpackage

// >>> hdl/mode_ctrl_if.sv
// carrier between register logic and the halt mode state machine
`timescale 1ns/100ps
`default_nettype none
interface mode_ctrl_if;
    import clk_mode_pkg::*;
    logic     halt;
    logic     wake;
    logic     halt_idle_select;
    logic     sysclk_keep_in_idle;
    logic     slow_select;
    op_mode_t mode;

    modport ctrl (output halt, output wake, output halt_idle_select,
                  output sysclk_keep_in_idle, output slow_select, input mode);
    modport fsm  (input halt, input wake, input halt_idle_select,
                  input sysclk_keep_in_idle, input slow_select, output mode);
endinterface
`default_nettype wire

// >>> hdl/osc_ready_flag.sv
// oscillator ready flag with stabilisation counter
`timescale 1ns/100ps
`default_nettype none
module osc_ready_flag #(
    parameter int DELAY = 1
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_stable,
    input  wire logic i_stop,
    output logic      o_ready
);
    import clk_mode_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             ready;
    } flag_state_t;

    flag_state_t st;
    flag_state_t next_st;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY - 1);

    always_comb begin
        next_st = st;
        if (i_stop || !i_stable) begin
            next_st.cnt   = '0;
            next_st.ready = 1'b0;
        end else if (!st.ready) begin
            if (st.cnt == LAST) begin
                next_st.ready = 1'b1;
            end else begin
                next_st.cnt = st.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_ready = st.ready;
endmodule
`default_nettype wire

// >>> hdl/halt_mode_fsm.sv
// operating mode state machine driven by halt and wake-up
`timescale 1ns/100ps
`default_nettype none
module halt_mode_fsm (
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    input  wire logic  i_ce,
    mode_ctrl_if.fsm   bus
);
    import clk_mode_pkg::*;

    typedef struct packed {
        op_mode_t mode;
    } fsm_state_t;

    fsm_state_t st;
    fsm_state_t next_st;

    always_comb begin
        next_st = st;
        case (st.mode)
            MODE_NORMAL, MODE_SLOW: begin
                if (bus.halt) begin
                    if (!bus.halt_idle_select) begin
                        next_st.mode = MODE_SLEEP;
                    end else if (bus.sysclk_keep_in_idle) begin
                        next_st.mode = MODE_IDLE_KEEP;
                    end else begin
                        next_st.mode = MODE_IDLE_STOP;
                    end
                end else begin
                    next_st.mode = bus.slow_select ? MODE_SLOW : MODE_NORMAL;
                end
            end
            MODE_SLEEP, MODE_IDLE_STOP, MODE_IDLE_KEEP: begin
                if (bus.wake) begin
                    next_st.mode = bus.slow_select ? MODE_SLOW : MODE_NORMAL;
                end
            end
            default: begin
                next_st.mode = MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st.mode <= MODE_NORMAL;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign bus.mode = st.mode;
endmodule
`default_nettype wire

// >>> hdl/system_clock_mode_control.sv
// system clock mode control: mode register, ready flags, halt modes
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module system_clock_mode_control (
    input  wire logic                          I_CLK_SYS,
    input  wire logic                          I_RST,
    input  wire logic                          I_CE,
    // cpu events and oscillator status
    input  wire logic                          I_HALT,
    input  wire logic                          I_WAKE,
    input  wire logic                          I_LOW_OSC_STABLE,
    input  wire logic                          I_HIGH_OSC_STABLE,
    // axi4-lite slave
    input  wire logic [clk_mode_pkg::ADDR_W-1:0] I_AWADDR,
    input  wire logic                          I_AWVALID,
    output logic                               O_AWREADY,
    input  wire logic [clk_mode_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic [3:0]                    I_WSTRB,
    input  wire logic                          I_WVALID,
    output logic                               O_WREADY,
    output logic [1:0]                         O_BRESP,
    output logic                               O_BVALID,
    input  wire logic                          I_BREADY,
    input  wire logic [clk_mode_pkg::ADDR_W-1:0] I_ARADDR,
    input  wire logic                          I_ARVALID,
    output logic                               O_ARREADY,
    output logic [clk_mode_pkg::DATA_W-1:0]    O_RDATA,
    output logic [1:0]                         O_RRESP,
    output logic                               O_RVALID,
    input  wire logic                          I_RREADY,
    // clock control outputs
    output logic                               O_CPU_CLK_EN,
    output logic                               O_SYSCLK_EN,
    output logic                               O_FAST_CLOCK_SELECT,
    output logic [2:0]                         O_CLOCK_DIVIDER_SELECT,
    output logic [2:0]                         O_MODE
);
    import clk_mode_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] waddr;
        logic [7:0]        wbyte;
        logic              wlane;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic [2:0]        clock_divider_select;
        logic              halt_idle_select;
        logic              fast_clock_select;
        logic              sysclk_keep_in_idle;
        logic              cpu_clk_en;
        logic              sysclk_en;
        logic [2:0]        mode;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic low_osc_ready_flag;
    logic high_osc_ready_flag;
    logic high_stop;

    mode_ctrl_if mc ();

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    halt_mode_fsm u_fsm (
        .i_clk (I_CLK_SYS),
        .i_rst (I_RST),
        .i_ce  (I_CE),
        .bus   (mc.fsm)
    );

    osc_ready_flag #(
        .DELAY (LOW_RDY_CYCLES)
    ) u_low_rdy (
        .i_clk    (I_CLK_SYS),
        .i_rst    (I_RST),
        .i_ce     (I_CE),
        .i_stable (I_LOW_OSC_STABLE),
        .i_stop   (1'b0),
        .o_ready  (low_osc_ready_flag)
    );

    // high oscillator is stopped in sleep and the fully stopped idle
    assign high_stop = (mc.mode == MODE_SLEEP) || (mc.mode == MODE_IDLE_STOP);

    osc_ready_flag #(
        .DELAY (HIGH_RDY_CYCLES)
    ) u_high_rdy (
        .i_clk    (I_CLK_SYS),
        .i_rst    (I_RST),
        .i_ce     (I_CE),
        .i_stable (I_HIGH_OSC_STABLE),
        .i_stop   (high_stop),
        .o_ready  (high_osc_ready_flag)
    );

    // ------------------------------------------------------------------
    // mode carrier
    // ------------------------------------------------------------------
    assign mc.halt                = I_HALT;
    assign mc.wake                = I_WAKE;
    assign mc.halt_idle_select    = st.halt_idle_select;
    assign mc.sysclk_keep_in_idle = st.sysclk_keep_in_idle;
    assign mc.slow_select         = !st.fast_clock_select &&
                                    ((st.clock_divider_select == DIV_LOW_A) ||
                                     (st.clock_divider_select == DIV_LOW_B));

    // ------------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------------
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input top_state_t        s,
        input logic              low_rdy,
        input logic              high_rdy
    );
        logic [DATA_W-1:0] w;
        w = '0;
        case (addr)
            ADDR_MODE_CTRL: begin
                w[DIV_SEL_MSB:DIV_SEL_LSB] = s.clock_divider_select;
                w[LOW_RDY_BIT]             = low_rdy;
                w[HIGH_RDY_BIT]            = high_rdy;
                w[IDLE_SEL_BIT]            = s.halt_idle_select;
                w[FAST_SEL_BIT]            = s.fast_clock_select;
            end
            ADDR_IDLE_CTRL: begin
                w[KEEP_BIT] = s.sysclk_keep_in_idle;
            end
            ADDR_MODE_STATUS: begin
                w[2:0] = s.mode;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    function automatic logic addr_ok(input logic [ADDR_W-1:0] addr);
        return (addr == ADDR_MODE_CTRL) || (addr == ADDR_IDLE_CTRL) ||
               (addr == ADDR_MODE_STATUS);
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // write address and data are taken in either order
        if (st.awready && I_AWVALID) begin
            next_st.aw_held = 1'b1;
            next_st.waddr   = I_AWADDR;
        end
        if (st.wready && I_WVALID) begin
            next_st.w_held = 1'b1;
            next_st.wbyte  = I_WDATA[7:0];
            next_st.wlane  = I_WSTRB[0];
        end

        // commit once both halves are held
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = addr_ok(st.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (st.wlane) begin
                case (st.waddr)
                    ADDR_MODE_CTRL: begin
                        next_st.clock_divider_select =
                            st.wbyte[DIV_SEL_MSB:DIV_SEL_LSB];
                        next_st.halt_idle_select  = st.wbyte[IDLE_SEL_BIT];
                        next_st.fast_clock_select = st.wbyte[FAST_SEL_BIT];
                        // ready flag bits are not stored
                    end
                    ADDR_IDLE_CTRL: begin
                        next_st.sysclk_keep_in_idle = st.wbyte[KEEP_BIT];
                    end
                    default: begin
                        next_st.w_held = 1'b0;
                    end
                endcase
            end
        end
        if (st.bvalid && I_BREADY) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;

        // read channel
        if (st.arready && I_ARVALID) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = read_word(I_ARADDR, st, low_osc_ready_flag,
                                       high_osc_ready_flag);
            next_st.rresp  = addr_ok(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rvalid && I_RREADY) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = !next_st.rvalid;

        // clock enables follow the operating mode
        case (mc.mode)
            MODE_NORMAL, MODE_SLOW: begin
                next_st.cpu_clk_en = 1'b1;
                next_st.sysclk_en  = 1'b1;
            end
            MODE_IDLE_KEEP: begin
                next_st.cpu_clk_en = 1'b0;
                next_st.sysclk_en  = 1'b1;
            end
            MODE_IDLE_STOP, MODE_SLEEP: begin
                next_st.cpu_clk_en = 1'b0;
                next_st.sysclk_en  = 1'b0;
            end
            default: begin
                next_st.cpu_clk_en = 1'b1;
                next_st.sysclk_en  = 1'b1;
            end
        endcase
        next_st.mode = mc.mode;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            st                      <= '0;
            st.awready              <= 1'b1;
            st.wready               <= 1'b1;
            st.arready              <= 1'b1;
            st.bresp                <= RESP_OKAY;
            st.rresp                <= RESP_OKAY;
            st.clock_divider_select <= RST_DIV_SEL;
            st.halt_idle_select     <= RST_IDLE_SEL;
            st.fast_clock_select    <= RST_FAST_SEL;
            st.sysclk_keep_in_idle  <= RST_KEEP;
            st.cpu_clk_en           <= 1'b1;
            st.sysclk_en            <= 1'b1;
            st.mode                 <= MODE_NORMAL;
        end else if (I_CE) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign O_AWREADY              = st.awready;
    assign O_WREADY               = st.wready;
    assign O_BVALID               = st.bvalid;
    assign O_BRESP                = st.bresp;
    assign O_ARREADY              = st.arready;
    assign O_RVALID               = st.rvalid;
    assign O_RDATA                = st.rdata;
    assign O_RRESP                = st.rresp;
    assign O_CPU_CLK_EN           = st.cpu_clk_en;
    assign O_SYSCLK_EN            = st.sysclk_en;
    assign O_FAST_CLOCK_SELECT    = st.fast_clock_select;
    assign O_CLOCK_DIVIDER_SELECT = st.clock_divider_select;
    assign O_MODE                 = st.mode;

endmodule
`default_nettype wire

// >>> verif/clk_mode_asserts.sv
// assertions on the ports of the clock mode control block
`timescale 1ns/100ps
`default_nettype none
module clk_mode_asserts (
    input wire logic        I_CLK_SYS,
    input wire logic        I_RST,
    input wire logic        I_HALT,
    input wire logic        I_ARVALID,
    input wire logic [7:0]  I_ARADDR,
    input wire logic        O_ARREADY,
    input wire logic        I_RREADY,
    input wire logic        O_RVALID,
    input wire logic [31:0] O_RDATA,
    input wire logic        I_BREADY,
    input wire logic        O_BVALID,
    input wire logic        O_CPU_CLK_EN,
    input wire logic        O_SYSCLK_EN,
    input wire logic [2:0]  O_MODE
);
    import clk_mode_pkg::*;
    default clocking dc @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    // ----------------
    // mode rules
    // ----------------
    property p_halt_stop;
        (I_HALT && (O_MODE inside {MODE_NORMAL, MODE_SLOW}))
            |-> ##2 (O_MODE inside {MODE_SLEEP, MODE_IDLE_STOP, MODE_IDLE_KEEP});
    endproperty
    a_halt_stop: assert property (p_halt_stop)
        else $error("halt did not stop the core");
    property p_cpu_en;
        O_CPU_CLK_EN == (O_MODE inside {MODE_NORMAL, MODE_SLOW});
    endproperty
    a_cpu_en: assert property (p_cpu_en)
        else $error("cpu clock enable disagrees with mode");
    property p_idle_keep;
        (O_MODE == MODE_IDLE_KEEP) |-> (O_SYSCLK_EN && !O_CPU_CLK_EN);
    endproperty
    a_idle_keep: assert property (p_idle_keep)
        else $error("system clock stopped in kept idle");
    property p_idle_stop;
        (O_MODE inside {MODE_SLEEP, MODE_IDLE_STOP}) |-> !O_SYSCLK_EN;
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("system clock running while stopped");
    property p_flag_low;
        (I_ARVALID && O_ARREADY && I_ARADDR == ADDR_MODE_CTRL
            && (O_MODE inside {MODE_SLEEP, MODE_IDLE_STOP})
            && $past(O_MODE) == O_MODE && $past(O_MODE, 2) == O_MODE)
            |=> !O_RDATA[HIGH_RDY_BIT];
    endproperty
    a_flag_low: assert property (p_flag_low)
        else $error("high ready flag set while stopped");
    // ----------------
    // bus handshakes
    // ----------------
    property p_read_lat;
        (I_ARVALID && O_ARREADY) |=> O_RVALID;
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("read answer late");
    property p_rd_hold;
        (O_RVALID && !I_RREADY) |=> (O_RVALID && $stable(O_RDATA));
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read answer dropped early");
    property p_wr_hold;
        (O_BVALID && !I_BREADY) |=> O_BVALID;
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write answer dropped early");
    c_sleep: cover property (O_MODE == MODE_SLEEP);
    c_idle_stop: cover property (O_MODE == MODE_IDLE_STOP);
    c_idle_keep: cover property (O_MODE == MODE_IDLE_KEEP);
endmodule
bind system_clock_mode_control clk_mode_asserts u_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_HALT(I_HALT), .I_ARVALID(I_ARVALID),
    .I_ARADDR(I_ARADDR), .O_ARREADY(O_ARREADY), .I_RREADY(I_RREADY),
    .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .I_BREADY(I_BREADY), .O_BVALID(O_BVALID),
    .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_SYSCLK_EN(O_SYSCLK_EN), .O_MODE(O_MODE));
`default_nettype wire

// >>> verif/cpu_core_model.sv
// model of the cpu core issuing halt and wake-up events
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
    input  wire logic i_clk,
    output var logic  o_halt,
    output var logic  o_wake
);
    initial begin
        o_halt = 1'b0;
        o_wake = 1'b0;
    end
    // one-cycle pulse after dly+1 idle cycles
    task automatic pulse(input logic sel, input int dly);
        repeat (dly) @(posedge i_clk);
        @(posedge i_clk);
        if (sel) begin
            o_halt <= 1'b1;
        end else begin
            o_wake <= 1'b1;
        end
        @(posedge i_clk);
        o_halt <= 1'b0;
        o_wake <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the clock mode control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import clk_mode_pkg::*;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic [1:0]  resp;
    } rd_exp_t;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, low_stb = 1'b0, high_stb = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic        rready = 1'b0, halt, wake, awready, wready, bvalid, arready, rvalid;
    logic        cpu_en, sys_en, fast_sel, f, idl, kp;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, last, seed = 32'h593C;
    logic [3:0]  wstrb = '0;
    logic [2:0]  div_sel, mode, d;
    logic [1:0]  bresp, rresp;
    op_mode_t    em;
    rd_exp_t     re;
    rd_exp_t     rq[$];
    logic [1:0]  bq[$];
    int          fails = 0, n_checks = 0;

    system_clock_mode_control uut (
        .I_CLK_SYS(clk), .I_RST(rst), .I_CE(ce), .I_HALT(halt), .I_WAKE(wake),
        .I_LOW_OSC_STABLE(low_stb), .I_HIGH_OSC_STABLE(high_stb),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
        .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
        .I_RREADY(rready), .O_CPU_CLK_EN(cpu_en), .O_SYSCLK_EN(sys_en),
        .O_FAST_CLOCK_SELECT(fast_sel), .O_CLOCK_DIVIDER_SELECT(div_sel), .O_MODE(mode));
    cpu_core_model cpu (.i_clk(clk), .o_halt(halt), .o_wake(wake));

    always #4 clk = ~clk;

    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [2:0] run_mode(input logic [2:0] dv, input logic fs);
        return (!fs && (dv == DIV_LOW_A || dv == DIV_LOW_B)) ? MODE_SLOW : MODE_NORMAL;
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s,
                      input logic [1:0] r);
        logic aw_p = 1'b1;
        logic w_p = 1'b1;
        bq.push_back(r);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= dt;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge clk);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] dt, input logic [31:0] m,
                      input logic [1:0] r);
        rq.push_back('{dt & m, m, r});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask

    // ----------------
    // result monitor
    // ----------------
    always @(posedge clk) begin
        if (rvalid && rready) begin
            re = rq.pop_front();
            check("rdata", rdata & re.mask, re.data);
            check("rresp", 32'(rresp), 32'(re.resp));
        end
        if (bvalid && bready) begin
            check("bresp", 32'(bresp), 32'(bq.pop_front()));
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end

    // ----------------
    // scenarios
    // ----------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_MODE_CTRL, 32'h1, 32'hFFFF_FFFF, RESP_OKAY);
        low_stb <= 1'b1;
        high_stb <= 1'b1;
        repeat (24) @(posedge clk);
        rd(ADDR_MODE_CTRL, 32'hD, 32'hFFFF_FFFF, RESP_OKAY);
        rd(ADDR_IDLE_CTRL, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = 3'(i);
            f = (i < 2) ? 1'b0 : seed[1];
            idl = seed[0];
            last = {24'h0, d, 3'b011, idl, f};
            wr(ADDR_MODE_CTRL, {seed[31:8], d, 3'b100, idl, f}, 4'hF, RESP_OKAY);
            rd(ADDR_MODE_CTRL, last, 32'hFFFF_FFFF, RESP_OKAY);
            check("div_sel", 32'(div_sel), 32'(d));
            check("fast_sel", 32'(fast_sel), 32'(f));
            check("mode", 32'(mode), 32'(run_mode(d, f)));
        end
        wr(ADDR_MODE_CTRL, 32'h0, 4'hE, RESP_OKAY);
        wr(8'h0C, 32'hFF, 4'hF, RESP_SLVERR);
        rd(8'h0C, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        rd(ADDR_MODE_CTRL, last, 32'hFFFF_FFFF, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            idl = i[1];
            kp = i[0];
            em = idl ? (kp ? MODE_IDLE_KEEP : MODE_IDLE_STOP) : MODE_SLEEP;
            wr(ADDR_MODE_CTRL, {24'h0, 3'h2, 3'b000, idl, 1'b1}, 4'h1, RESP_OKAY);
            wr(ADDR_IDLE_CTRL, {31'h0, kp}, 4'h1, RESP_OKAY);
            seed = lfsr(seed);
            cpu.pulse(1'b1, int'(seed[1:0]));
            repeat (3) @(posedge clk);
            check("mode", 32'(mode), 32'(em));
            check("cpu_en", 32'(cpu_en), 32'h0);
            check("sys_en", 32'(sys_en), 32'(idl & kp));
            rd(ADDR_MODE_STATUS, 32'(em), 32'h7, RESP_OKAY);
            rd(ADDR_MODE_CTRL, (em == MODE_IDLE_KEEP) ? 32'h4 : 32'h0, 32'h4, RESP_OKAY);
            cpu.pulse(1'b0, 0);
            repeat (12) @(posedge clk);
            rd(ADDR_MODE_CTRL, (em == MODE_IDLE_KEEP) ? 32'h4 : 32'h0, 32'h4, RESP_OKAY);
            rd(ADDR_MODE_CTRL, 32'h4, 32'h4, RESP_OKAY);
            check("mode", 32'(mode), 32'(MODE_NORMAL));
        end
        print_verdict();
    end
endmodule
`default_nettype wire
